// >>> hw/weekly_timer_pkg.sv
// Shared constants for the weekly schedule timer
package weekly_timer_pkg;

   localparam int          WORD_W        = 16;           // Width of one data register word
   localparam int          DAY_W         = 7;            // One bit per day of the week
   localparam int          WORDS_PER_ENT = 3;            // Day mask, ON time, OFF time
   localparam int          MAX_ENT_DEF   = 20;           // Largest entry count served
   localparam int          ADDR_W        = 11;           // Data register address width

   // Word positions inside one entry
   localparam logic [1:0]  FLD_DAYS      = 2'h0;         // Day selection word
   localparam logic [1:0]  FLD_ON        = 2'h1;         // ON time word
   localparam logic [1:0]  FLD_OFF       = 2'h2;         // OFF time word

   // Time limits, times stored as hour*100+minute
   localparam logic [15:0] ON_TIME_MAX   = 16'h0937;     // 23:59
   localparam logic [15:0] OFF_TIME_MAX  = 16'h0960;     // 24:00
   localparam logic [15:0] MINUTE_MAX    = 16'h003B;     // 59
   localparam logic [15:0] HHMM_SCALE    = 16'h0064;     // 100 between hour and minute
   localparam logic [14:0] MIN_PER_HOUR  = 15'h003C;     // 60
   localparam logic [14:0] MIN_PER_DAY   = 15'h05A0;     // 1440
   localparam logic [14:0] MIN_PER_WEEK  = 15'h2760;     // 10080
   localparam logic [14:0] DIST_NONE     = 15'h7FFF;     // No event seen yet

   // Reset values
   localparam logic [15:0] WORD_RST      = 16'h0000;     // Cleared word
   localparam logic [4:0]  IDX_RST       = 5'h00;        // First entry

   // Default entry: every day, ON 08:00, OFF 17:00
   localparam logic [47:0] DEF_ENTRY     = {16'h06A4, 16'h0320, 16'h007F};

endpackage

// >>> hw/schedule_ram.sv
// Data register area of the schedule, one write and one registered read port
`timescale 1ns/1ps
module schedule_ram
   import weekly_timer_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = 60,
   parameter int AW    = 6
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   // Storage words, no reset: software or the load sequence fills them
   logic [WIDTH-1:0] mem [DEPTH];

   // Refuse an address width that cannot reach every word
   initial begin
      if ((1 << AW) < DEPTH) begin
         $error("schedule_ram: address width too small");
      end
   end

   // Write port
   always_ff @(posedge clk) begin
      if (wr_en && (int'(wr_addr) < DEPTH)) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read, out of range reads as zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (int'(rd_addr) < DEPTH) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= '0;
      end
   end

endmodule

// >>> hw/weekly_schedule_timer.sv
// Weekly schedule comparator driving one level or pulse output
//
// Contract
// - Run low: no evaluation, output low
// - ON entry day and time sets output
// - OFF entry day and time clears output
// - Pulse mode: one-scan pulse, OFF unused
// - Pulse mode run rise: pulse on ON match
// - Level mode: ON sets, OFF clears
// - One pulse mode setting for all entries
// - One to twenty entries: days, ON, OFF
// - ON time 00:00 to 23:59
// - OFF time 00:00 to 24:00
// - Same time: higher index entry wins
// - Constant mode: fixed entries, not alterable
// - Register mode: entries from writable registers
// - Area is three words per entry
// - Load input copies defaults into area
// - Load input ignored in constant mode
// - Entry words: days, ON, OFF in order
// - Error on bad time, minute, no days
// - Run rise recomputes output from now
// - Rewritten values act at next instant
`timescale 1ns/1ps
module weekly_schedule_timer
   import weekly_timer_pkg::*;
#(
   parameter int                               MAX_ENTRIES   = MAX_ENT_DEF,
   parameter logic [MAX_ENT_DEF*48-1:0]        DEFAULT_TABLE = {MAX_ENT_DEF{DEF_ENTRY}}
) (
   input  wire logic                SYS_CLK,
   input  wire logic                RESET_N,
   input  wire logic                RUN,
   input  wire logic                DEFAULTS_LOAD_INPUT,
   input  wire logic                SCAN_TICK,
   input  wire logic                PULSE_MODE,
   input  wire logic                REG_MODE,
   input  wire logic [4:0]          SCHEDULE_ENTRY_COUNT,
   input  wire logic [ADDR_W-1:0]   SCHEDULE_BASE_REGISTER,
   input  wire logic [2:0]          CUR_DAY,
   input  wire logic [4:0]          CUR_HOUR,
   input  wire logic [5:0]          CUR_MIN,
   input  wire logic                DREG_WR,
   input  wire logic [ADDR_W-1:0]   DREG_ADDR,
   input  wire logic [WORD_W-1:0]   DREG_WDATA,
   output logic                     SCHED_OUT,
   output logic                     EXEC_ERROR,
   output logic                     LOAD_BUSY
);
   localparam int DEPTH = MAX_ENTRIES * WORDS_PER_ENT;   // Words in the area
   localparam int AW    = 6;                             // Area word address width
   // Refuse entry counts the area cannot hold
   initial begin
      if (MAX_ENTRIES < 1 || MAX_ENTRIES > MAX_ENT_DEF) begin
         $error("weekly_schedule_timer: MAX_ENTRIES out of 1..20");
      end
   end
   // Scan sequencer states, Gray along idle, address, data, done
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_DATA = 3'h3,
      ST_DONE = 3'h2,
      ST_LOAD = 3'h6
   } state_e;
   // Minute field of an hour*100+minute word
   function automatic logic [15:0] minute_of(input logic [15:0] v);
      minute_of = v % HHMM_SCALE;
   endfunction
   // Minutes since midnight of an hour*100+minute word
   function automatic logic [14:0] to_minutes(input logic [15:0] v);
      logic [15:0] hrs;
      logic [15:0] mins;
      hrs        = v / HHMM_SCALE;
      mins       = minute_of(v);
      to_minutes = 15'(hrs[14:0] * MIN_PER_HOUR) + mins[14:0];
   endfunction
   // Minutes since the newest selected occurrence of an event, week wrap
   function automatic logic [14:0] week_dist(input logic [DAY_W-1:0] days,
                                             input logic [14:0]      t,
                                             input logic [14:0]      now);
      logic [15:0] ev;
      logic [15:0] diff;
      logic [14:0] best;
      best = DIST_NONE;
      for (int d = 0; d < DAY_W; d++) begin
         ev   = 16'(15'(d) * MIN_PER_DAY) + 16'(t);
         diff = 16'(now) + 16'(MIN_PER_WEEK) - ev;
         if (diff >= 16'(MIN_PER_WEEK)) begin
            diff = diff - 16'(MIN_PER_WEEK);
         end
         if (days[d] && (diff[14:0] < best)) begin
            best = diff[14:0];
         end
      end
      week_dist = best;
   endfunction
   // Pin synchronisers, three stages each
   logic [2:0]        run_sync_reg;         // Run input stages
   logic [2:0]        load_sync_reg;        // Load input stages
   logic              run_lvl_reg;          // Filtered run level
   logic              load_lvl_reg;         // Filtered load level
   // Sequencer state
   state_e            state_reg;            // Current state
   logic [4:0]        idx_reg;              // Entry being walked
   logic [1:0]        fld_reg;              // Word within the entry
   logic [AW-1:0]     load_addr_reg;        // Word being loaded
   logic [14:0]       now_reg;              // Week minute of this scan
   logic [14:0]       last_now_reg;         // Week minute of previous scan
   logic [15:0]       days_reg;             // Day word of current entry
   logic [15:0]       on_reg;               // ON word of current entry
   logic [14:0]       best_dist_reg;        // Newest event distance so far
   logic              best_on_reg;          // Newest event is an ON
   logic              err_acc_reg;          // Errors seen this scan
   logic              rise_pend_reg;        // Run rose since last scan
   logic              level_reg;            // Level mode state
   logic [15:0]       const_q_reg;          // Registered constant word
   // Area read and write wires
   logic [WORD_W-1:0] ram_q;                // Register mode word
   logic [WORD_W-1:0] rd_word;              // Word of the selected source
   logic [AW-1:0]     rd_addr;              // Walk address
   logic [ADDR_W:0]   host_rel;             // Host address minus base
   logic              host_hit;             // Host write lands in the area
   logic              ram_we;               // Area write strobe
   logic [AW-1:0]     ram_waddr;            // Area write address
   logic [WORD_W-1:0] ram_wdata;            // Area write data
   logic [4:0]        ent_cnt;              // Usable entry count
   logic              cnt_bad;              // Count outside 1..max
   logic [6:0]        area_words;           // Words in use
   // Entry checks and candidate events
   logic              day_ok;               // Some day selected
   logic              on_ok;                // ON time in range
   logic              off_ok;               // OFF time in range
   logic              ent_ok;               // Entry may be used
   logic [14:0]       on_dist;              // Age of newest ON instant
   logic [14:0]       off_dist;             // Age of newest OFF instant
   logic [14:0]       b1_dist;              // Best after ON
   logic              b1_on;                // Kind after ON
   logic [14:0]       b2_dist;              // Best after OFF
   logic              b2_on;                // Kind after OFF
   logic              last_ent;             // Walking the final entry
   logic              fresh;                // New minute or run rise
   logic              hit_now;              // An event falls on this minute
   logic              pulse_now;            // Pulse for this scan
   logic              level_next;           // Level after this scan
   logic              run_rise;             // Filtered run rising edge
   logic              load_rise;            // Filtered load rising edge
   logic [15:0]       const_word;           // Constant table word
   // Count and area size, product widened before it can overflow
   assign cnt_bad    = (SCHEDULE_ENTRY_COUNT == 5'h00) ||
                       (int'(SCHEDULE_ENTRY_COUNT) > MAX_ENTRIES);
   assign ent_cnt    = cnt_bad ? 5'(MAX_ENTRIES) : SCHEDULE_ENTRY_COUNT;
   assign area_words = 7'(ent_cnt) * 7'h03;
   // Walk address: entry times three plus word; days, ON, OFF order
   assign rd_addr    = AW'(idx_reg) * AW'(3) + AW'(fld_reg);
   assign const_word = DEFAULT_TABLE[16*int'(rd_addr) +: 16];
   assign rd_word    = REG_MODE ? ram_q : const_q_reg;
   // Host writes into the area, relative to the base register
   assign host_rel   = {1'b0, DREG_ADDR} - {1'b0, SCHEDULE_BASE_REGISTER};
   assign host_hit   = DREG_WR && REG_MODE && !host_rel[ADDR_W] &&
                       (host_rel < (ADDR_W+1)'(area_words));
   assign ram_we     = (state_reg == ST_LOAD) || host_hit;
   assign ram_waddr  = (state_reg == ST_LOAD) ? load_addr_reg : host_rel[AW-1:0];
   assign ram_wdata  = (state_reg == ST_LOAD) ? DEFAULT_TABLE[16*int'(load_addr_reg) +: 16]
                                              : DREG_WDATA;
   // Entry validity, times held as hour*100+minute
   assign day_ok     = days_reg[DAY_W-1:0] != 7'h00;
   assign on_ok      = (on_reg <= ON_TIME_MAX) && (minute_of(on_reg) <= MINUTE_MAX);
   assign off_ok     = (rd_word <= OFF_TIME_MAX) &&
                       (minute_of(rd_word) <= MINUTE_MAX);
   assign ent_ok     = day_ok && on_ok && off_ok;
   // Distance of now from each event, 24:00 wraps to next day
   assign on_dist    = week_dist(days_reg[DAY_W-1:0], to_minutes(on_reg), now_reg);
   assign off_dist   = week_dist(days_reg[DAY_W-1:0], to_minutes(rd_word), now_reg);
   // Later entries win ties, OFF ignored in pulse mode
   assign b1_on      = ent_ok && (on_dist <= best_dist_reg) ? 1'b1 : best_on_reg;
   assign b1_dist    = ent_ok && (on_dist <= best_dist_reg) ? on_dist : best_dist_reg;
   assign b2_on      = ent_ok && !PULSE_MODE && (off_dist <= b1_dist) ? 1'b0 : b1_on;
   assign b2_dist    = ent_ok && !PULSE_MODE && (off_dist <= b1_dist) ? off_dist : b1_dist;
   assign last_ent   = (idx_reg == ent_cnt - 5'h01);
   // Scan result
   assign fresh      = (now_reg != last_now_reg) || rise_pend_reg;
   assign hit_now    = (best_dist_reg == 15'h0000) && fresh;
   assign pulse_now  = hit_now && best_on_reg;
   assign level_next = rise_pend_reg ? ((best_dist_reg != DIST_NONE) && best_on_reg)
                     : hit_now ? best_on_reg : level_reg;
   assign run_rise   = (run_sync_reg[1] == run_sync_reg[2]) && run_sync_reg[1] && !run_lvl_reg;
   assign load_rise  = (load_sync_reg[1] == load_sync_reg[2]) && load_sync_reg[1] &&
                       !load_lvl_reg;
   // Area storage
   schedule_ram #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_ram (
      .clk     (SYS_CLK),
      .rst_n   (RESET_N),
      .wr_en   (ram_we),
      .wr_addr (ram_waddr),
      .wr_data (ram_wdata),
      .rd_addr (rd_addr),
      .rd_data (ram_q)
   );
   // Pin synchronisers; level follows once stages two and three agree
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         run_sync_reg  <= 3'h0;
         load_sync_reg <= 3'h0;
         run_lvl_reg   <= 1'b0;
         load_lvl_reg  <= 1'b0;
      end else begin
         run_sync_reg  <= {run_sync_reg[1:0], RUN};
         load_sync_reg <= {load_sync_reg[1:0], DEFAULTS_LOAD_INPUT};
         if (run_sync_reg[1] == run_sync_reg[2]) begin
            run_lvl_reg <= run_sync_reg[2];
         end
         if (load_sync_reg[1] == load_sync_reg[2]) begin
            load_lvl_reg <= load_sync_reg[2];
         end
      end
   end
   // Constant words come out of a register, like the area
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         const_q_reg <= WORD_RST;
      end else begin
         const_q_reg <= const_word;
      end
   end
   // Run rise remembered until the scan that uses it; set beats clear
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rise_pend_reg <= 1'b0;
      end else if (run_rise) begin
         rise_pend_reg <= 1'b1;
      end else if (!run_lvl_reg || state_reg == ST_DONE) begin
         rise_pend_reg <= 1'b0;
      end
   end
   // Scan walk, default load and output update
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg     <= ST_IDLE;
         idx_reg       <= IDX_RST;
         fld_reg       <= FLD_DAYS;
         load_addr_reg <= '0;
         now_reg       <= 15'h0000;
         last_now_reg  <= DIST_NONE;
         days_reg      <= WORD_RST;
         on_reg        <= WORD_RST;
         best_dist_reg <= DIST_NONE;
         best_on_reg   <= 1'b0;
         err_acc_reg   <= 1'b0;
         level_reg     <= 1'b0;
         SCHED_OUT     <= 1'b0;
         EXEC_ERROR    <= 1'b0;
         LOAD_BUSY     <= 1'b0;
      end else begin
         case (state_reg)
            // Wait for a load request or a scan
            ST_IDLE: begin
               if (load_rise && REG_MODE) begin
                  state_reg     <= ST_LOAD;
                  load_addr_reg <= '0;
                  LOAD_BUSY     <= 1'b1;
               end else if (SCAN_TICK && run_lvl_reg) begin
                  state_reg     <= ST_ADDR;
                  idx_reg       <= IDX_RST;
                  fld_reg       <= FLD_DAYS;
                  now_reg       <= 15'(CUR_DAY * MIN_PER_DAY) +
                                   15'(CUR_HOUR * MIN_PER_HOUR) + 15'(CUR_MIN);
                  best_dist_reg <= DIST_NONE;
                  best_on_reg   <= 1'b0;
                  err_acc_reg   <= cnt_bad;
               end
            end
            // Address presented, word arrives next cycle
            ST_ADDR: begin
               state_reg <= ST_DATA;
            end
            // Capture a word; the OFF word closes the entry
            ST_DATA: begin
               state_reg <= ST_ADDR;
               case (fld_reg)
                  FLD_DAYS: begin
                     days_reg <= rd_word;
                     fld_reg  <= FLD_ON;
                  end
                  FLD_ON: begin
                     on_reg  <= rd_word;
                     fld_reg <= FLD_OFF;
                  end
                  default: begin
                     best_dist_reg <= b2_dist;
                     best_on_reg   <= b2_on;
                     err_acc_reg   <= err_acc_reg || !ent_ok;
                     fld_reg       <= FLD_DAYS;
                     idx_reg       <= idx_reg + 5'h01;
                     if (last_ent) begin
                        state_reg <= ST_DONE;
                     end
                  end
               endcase
            end
            // Publish the result, held until the next scan
            ST_DONE: begin
               state_reg    <= ST_IDLE;
               last_now_reg <= now_reg;
               EXEC_ERROR   <= err_acc_reg;
               level_reg    <= level_next;
               SCHED_OUT    <= PULSE_MODE ? pulse_now : level_next;
            end
            // Copy the default table into the area
            ST_LOAD: begin
               load_addr_reg <= load_addr_reg + AW'(1);
               if (7'(load_addr_reg) == area_words - 7'h01) begin
                  state_reg <= ST_IDLE;
                  LOAD_BUSY <= 1'b0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // Stopped block holds its output low
         if (!run_lvl_reg) begin
            SCHED_OUT    <= 1'b0;
            level_reg    <= 1'b0;
            last_now_reg <= DIST_NONE;
         end
      end
   end
endmodule

// >>> test/weekly_schedule_timer_properties.sv
// Port timing checker for the weekly schedule timer
`timescale 1ns/1ps
module sched_props
   import weekly_timer_pkg::*;
(
   input wire logic       SYS_CLK,
   input wire logic       RESET_N,
   input wire logic       RUN,
   input wire logic       DEFAULTS_LOAD_INPUT,
   input wire logic       SCAN_TICK,
   input wire logic       PULSE_MODE,
   input wire logic       REG_MODE,
   input wire logic [4:0] SCHEDULE_ENTRY_COUNT,
   input wire logic       SCHED_OUT,
   input wire logic       LOAD_BUSY
);
   int tick_age;   // Cycles since the latest tick
   int scan_len;   // Scan length for the current count
   assign scan_len = 2 + 6 * int'(SCHEDULE_ENTRY_COUNT);
   // Age of the latest tick, saturating
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tick_age <= 0;
      end else if (SCAN_TICK) begin
         tick_age <= 0;
      end else if (tick_age < 1000) begin
         tick_age <= tick_age + 1;
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   a_run_low_out: assert property ((!RUN) [*7] |-> !SCHED_OUT)
      else $error("output high while run is low");
   a_rise_run_high: assert property ($rose(SCHED_OUT) |-> RUN)
      else $error("output rose without run");
   a_rise_at_scan: assert property ($rose(SCHED_OUT) |-> tick_age >= scan_len - 1
      && tick_age <= scan_len + 1)
      else $error("output rose away from a scan end");
   a_fall_at_scan: assert property ($fell(SCHED_OUT) && RUN && $past(RUN, 8)
      |-> tick_age >= scan_len - 1 && tick_age <= scan_len + 1)
      else $error("output fell away from a scan end");
   a_pulse_one_scan: assert property ($rose(SCHED_OUT) && PULSE_MODE
      |-> ##[1:130] !SCHED_OUT)
      else $error("pulse lasted too long");
   a_load_min_len: assert property ($rose(LOAD_BUSY) |-> LOAD_BUSY [*3])
      else $error("copy too short");
   a_load_end: assert property ($rose(LOAD_BUSY) |-> ##[3:61] !LOAD_BUSY)
      else $error("copy did not end");
   a_load_reg_only: assert property ($rose(LOAD_BUSY)
      |-> $past(REG_MODE) && $past(DEFAULTS_LOAD_INPUT))
      else $error("copy without cause");
   a_out_hold_load: assert property (LOAD_BUSY && $past(LOAD_BUSY) |-> $stable(SCHED_OUT))
      else $error("output moved during copy");
   c_pulse: cover property ($rose(SCHED_OUT) && PULSE_MODE);
   c_level_off: cover property ($fell(SCHED_OUT) && RUN);
   c_load: cover property ($rose(LOAD_BUSY));
endmodule
bind weekly_schedule_timer sched_props sched_props_i (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .RUN(RUN), .DEFAULTS_LOAD_INPUT(DEFAULTS_LOAD_INPUT), .SCAN_TICK(SCAN_TICK),
   .PULSE_MODE(PULSE_MODE), .REG_MODE(REG_MODE), .SCHEDULE_ENTRY_COUNT(SCHEDULE_ENTRY_COUNT),
   .SCHED_OUT(SCHED_OUT), .LOAD_BUSY(LOAD_BUSY));

// >>> test/tb_top.sv
// Self-checking bench for the weekly schedule timer
`timescale 1ns/1ps
module tb_top;
   import weekly_timer_pkg::*;
   localparam logic [ADDR_W-1:0] BASE = 11'h010;   // Ordinary area start, no bank span
   logic              clk = 1'b0, rst_n = 1'b0, run = 1'b0, defaults_load_input = 1'b0, tick = 1'b0;
   logic              pulse = 1'b0, regm = 1'b1, wr = 1'b0, q, err, busy;
   logic [4:0]        cnt = 5'h02, hr = 5'h00;
   logic [5:0]        mi = 6'h00;
   logic [2:0]        day = 3'h0;
   logic [ADDR_W-1:0] wa = 11'h000;
   logic [WORD_W-1:0] wd = 16'h0000;
   int                err_count = 0, checks = 0, seed = 43515, st = 0, last_m = -1;
   int                days [20], on_t [20], off_t [20];   // Model entry table
   bit                first = 1'b1;                       // Next scan follows run rise
   // 200 MHz clock
   always #2.5 clk = ~clk;
   weekly_schedule_timer weekly_schedule_timer_i (.SYS_CLK(clk), .RESET_N(rst_n), .RUN(run),
      .DEFAULTS_LOAD_INPUT(defaults_load_input), .SCAN_TICK(tick), .PULSE_MODE(pulse), .REG_MODE(regm),
      .SCHEDULE_ENTRY_COUNT(cnt), .SCHEDULE_BASE_REGISTER(BASE), .CUR_DAY(day),
      .CUR_HOUR(hr), .CUR_MIN(mi), .DREG_WR(wr), .DREG_ADDR(wa), .DREG_WDATA(wd),
      .SCHED_OUT(q), .EXEC_ERROR(err), .LOAD_BUSY(busy));
   // Minutes since midnight of an hhmm value
   function automatic int mm(int t);
      return (t / 100) * 60 + t % 100;
   endfunction
   // Entry passes the range checks
   function automatic bit good(int i);
      return days[i] != 0 && on_t[i] <= 2359 && off_t[i] <= 2400 && on_t[i] % 100 <= 59
         && off_t[i] % 100 <= 59;
   endfunction
   // Event at week minute m: -1 none, 0 off, 1 on; later entry and OFF win
   function automatic int ev(int m, bit on_only);
      int r;
      r = -1;
      for (int i = 0; i < cnt; i++)
         for (int d = 0; d < 7; d++)
            if (good(i) && days[i][d]) begin
               if ((d * 1440 + mm(on_t[i])) % 10080 == m) r = 1;
               if (!on_only && (d * 1440 + mm(off_t[i])) % 10080 == m) r = 0;
            end
      return r;
   endfunction
   // Model table back to the default entry
   task automatic defs;
      for (int i = 0; i < 20; i++) begin
         days[i] = 127;
         on_t[i] = 800;
         off_t[i] = 1700;
      end
   endtask
   // Closing report
   task automatic close_out;
      $display("Mismatches %0d, comparisons %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Compare one bit
   task automatic chk(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: design %b, model %b", $time, got, exp);
      end
   endtask
   // One scan at a day and time, then compare with the model
   task automatic scan(input int d, input int h, input int m);
      int  w;
      bit  bad;
      w = d * 1440 + h * 60 + m;
      bad = 1'b0;
      @(posedge clk);
      day <= 3'(d);
      hr <= 5'(h);
      mi <= 6'(m);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (3 + 6 * cnt) @(posedge clk);
      #1;
      if (!run) st = 0;
      else if (pulse) st = int'((first || w != last_m) && ev(w, 1) == 1);
      else if (first) begin
         st = 0;
         for (int k = 10079; k >= 0; k--)
            if (ev((w - k + 10080) % 10080, 0) >= 0) st = ev((w - k + 10080) % 10080, 0);
      end else if (w != last_m && ev(w, 0) >= 0) st = ev(w, 0);
      for (int i = 0; i < cnt; i++) bad |= !good(i);
      chk(q, 1'(st));
      if (run) chk(err, bad);
      if (run) last_m = w;
      if (run) first = 1'b0;
   endtask
   // Change the run input and let it settle
   task automatic set_run(input logic v);
      @(posedge clk);
      run <= v;
      repeat (8) @(posedge clk);
      first = 1'b1;
   endtask
   // Write one area word at an offset
   task automatic put(input int o, input int v);
      @(posedge clk);
      wr <= 1'b1;
      wa <= BASE + 11'(o);
      wd <= 16'(v);
      @(posedge clk);
      wr <= 1'b0;
      if (regm) begin
         case (o % 3)
            0: days[o / 3] = v;
            1: on_t[o / 3] = v;
            default: off_t[o / 3] = v;
         endcase
      end
   endtask
   // Pulse the load input, expecting a copy or none
   task automatic load(input bit exp);
      int n;
      int k;
      n = 0;
      k = 0;
      @(posedge clk);
      defaults_load_input <= 1'b1;
      while (!busy && n < 12) begin
         @(posedge clk);
         n++;
      end
      chk(busy, exp);
      while (busy && k < 100) begin
         @(posedge clk);
         k++;
      end
      if (k == 100) begin
         err_count++;
         close_out();
      end
      defaults_load_input <= 1'b0;
      repeat (6) @(posedge clk);
      if (regm) defs();
   endtask
   // Main sequence
   int                offs [4] = '{1, 2, 4, 3};           // Offsets spoilt in turn
   int                badv [4] = '{2400, 2401, 860, 0};   // Bad value for each offset
   initial begin
      int keep;
      defs();
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      scan(1, 8, 0);
      load(1'b1);
      put(1, 800);
      put(2, 900);
      put(4, 900);
      put(5, 1000);
      set_run(1'b1);
      scan(1, 7, 59);
      scan(1, 8, 0);
      scan(1, 8, 0);
      scan(1, 9, 0);
      scan(1, 10, 0);
      put(1, 1100);
      scan(1, 10, 30);
      scan(1, 11, 0);
      for (int j = 0; j < 4; j++) begin
         keep = offs[j] % 3 == 0 ? days[offs[j] / 3] : on_t[offs[j] / 3];
         put(offs[j], badv[j]);
         scan(1, 12 + j, 30);
         put(offs[j], j == 1 ? 1000 : keep);
      end
      put(5, 2400);
      put(4, 2359);
      scan(1, 23, 59);
      scan(2, 0, 0);
      set_run(1'b0);
      pulse <= 1'b1;
      set_run(1'b1);
      scan(2, 11, 0);
      scan(2, 11, 0);
      scan(2, 23, 59);
      scan(3, 0, 0);
      set_run(1'b0);
      pulse <= 1'b0;
      regm <= 1'b0;
      defs();
      put(1, 500);
      load(1'b0);
      set_run(1'b1);
      repeat (12) scan(($random(seed) & 32'h7FFF) % 7, ($random(seed) & 32'h7FFF) % 24,
         ($random(seed) & 32'h7FFF) % 60);
      scan(4, 8, 0);
      scan(4, 17, 0);
      close_out();
   end
endmodule
